// ### vft_pkg.sv
// Shared constants, layouts and decode for the vertical frame timer.
`default_nettype none
package vft_pkg;

  localparam int VFT_NUM = 2;
  localparam int VFT_W = 16;
  localparam int VFT_NSEL = 8;

  // Register indices; the APB byte address is four times the index.
  localparam logic [31:0] VFT_IDX_IRQ_LINE_0 = 32'h0182020a;
  localparam logic [31:0] VFT_IDX_SYNC_END_0 = 32'h0182020e;
  localparam logic [31:0] VFT_IDX_AREA_START_0 = 32'h01820216;
  localparam logic [31:0] VFT_IDX_VBLANK_START_0 = 32'h0182021e;
  localparam logic [31:0] VFT_IDX_VBLANK_END_0 = 32'h01820212;
  localparam logic [31:0] VFT_IDX_VERTICAL_TOTAL_0 = 32'h01820222;
  localparam logic [31:0] VFT_IDX_CONTROL_0 = 32'h01820290;
  localparam logic [31:0] VFT_IDX_LINE_COUNT_0 = 32'h0182023e;
  localparam logic [31:0] VFT_IDX_IRQ_LINE_1 = 32'h0182024a;
  localparam logic [31:0] VFT_IDX_SYNC_END_1 = 32'h0182024e;
  localparam logic [31:0] VFT_IDX_AREA_START_1 = 32'h01820256;
  localparam logic [31:0] VFT_IDX_VBLANK_START_1 = 32'h0182025e;
  localparam logic [31:0] VFT_IDX_VBLANK_END_1 = 32'h01820252;
  localparam logic [31:0] VFT_IDX_VERTICAL_TOTAL_1 = 32'h01820262;
  localparam logic [31:0] VFT_IDX_CONTROL_1 = 32'h01820292;
  localparam logic [31:0] VFT_IDX_LINE_COUNT_1 = 32'h0182027e;

  // Slot numbers inside one timer; the last slot is the read-only counter.
  localparam logic [2:0] VFT_SEL_IRQ_LINE = 3'h0;
  localparam logic [2:0] VFT_SEL_SYNC_END = 3'h1;
  localparam logic [2:0] VFT_SEL_AREA_START = 3'h2;
  localparam logic [2:0] VFT_SEL_VBLANK_START = 3'h3;
  localparam logic [2:0] VFT_SEL_VBLANK_END = 3'h4;
  localparam logic [2:0] VFT_SEL_VERTICAL_TOTAL_VALUE = 3'h5;
  localparam logic [2:0] VFT_SEL_CONTROL = 3'h6;
  localparam logic [2:0] VFT_SEL_LINE_COUNT = 3'h7;

  localparam logic [31:0] VFT_IDX_TAB [VFT_NUM][VFT_NSEL] = '{
    '{VFT_IDX_IRQ_LINE_0, VFT_IDX_SYNC_END_0, VFT_IDX_AREA_START_0,
      VFT_IDX_VBLANK_START_0, VFT_IDX_VBLANK_END_0,
      VFT_IDX_VERTICAL_TOTAL_0, VFT_IDX_CONTROL_0, VFT_IDX_LINE_COUNT_0},
    '{VFT_IDX_IRQ_LINE_1, VFT_IDX_SYNC_END_1, VFT_IDX_AREA_START_1,
      VFT_IDX_VBLANK_START_1, VFT_IDX_VBLANK_END_1,
      VFT_IDX_VERTICAL_TOTAL_1, VFT_IDX_CONTROL_1, VFT_IDX_LINE_COUNT_1}};

  // Frame timer control field positions.
  localparam int VFT_CTL_ENABLE = 0;
  localparam int VFT_CTL_INTERLACE = 1;
  localparam int VFT_CTL_COMPOSITE = 2;
  localparam int VFT_CTL_IIS = 3;

  localparam logic [15:0] VFT_REG_RST = 16'h0000;
  localparam logic [15:0] VFT_CNT_RST = 16'h0000;
  localparam logic [15:0] VFT_CNT_ONE = 16'h0001;

  typedef struct packed {
    logic [15:0] irq_line;
    logic [15:0] sync_end;
    logic [15:0] area_start;
    logic [15:0] vblank_start;
    logic [15:0] vblank_end;
    logic [15:0] vertical_total_value;
    logic [15:0] control;
  } vft_vregs_t;

  // Strobes and pulse shapes from the horizontal half, one-cycle strobes.
  typedef struct packed {
    logic line_end;
    logic midline;
    logic hsync_n;
    logic hblank_n;
    logic equalize_n;
    logic serrate_n;
  } vft_hin_t;

  typedef struct packed {
    logic vsync_n;
    logic vblank_n;
    logic cblank_n;
    logic composite_sync_output_n;
    logic varea;
    logic serration;
    logic equalization;
  } vft_vout_t;

  typedef struct packed {
    logic hit;
    logic ro;
    logic inst;
    logic [2:0] sel;
  } vft_dec_t;

  function automatic vft_dec_t vft_decode(input logic [31:0] addr);
    vft_dec_t d;
    d = '0;
    for (int i = 0; i < VFT_NUM; i++)
    begin
      for (int s = 0; s < VFT_NSEL; s++)
      begin
        if (addr == {VFT_IDX_TAB[i][s][29:0], 2'b00})
        begin
          d.hit = 1'b1;
          d.inst = i[0];
          d.sel = s[2:0];
          d.ro = (s[2:0] == VFT_SEL_LINE_COUNT);
        end
      end
    end
    return d;
  endfunction

endpackage
`default_nettype wire

// ### vft_regbank.sv
// Storage for the timing value registers of both frame timers.
`timescale 1ns/1ps
`default_nettype none
module vft_regbank (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Write port.
  input wire logic i_wr_en,
  input wire logic i_wr_inst,
  input wire logic [2:0] i_wr_sel,
  input wire logic [15:0] i_wr_data,
  // Read port; data appear registered one cycle later.
  input wire logic i_rd_en,
  input wire vft_pkg::vft_dec_t i_rd_dec,
  input wire logic [1:0][15:0] i_line_cnt,
  output logic [31:0] o_rd_data_ff,
  // Live values for the timers.
  output vft_pkg::vft_vregs_t [1:0] o_regs
);
  import vft_pkg::*;

  logic [15:0] mem_ff [VFT_NUM][VFT_SEL_LINE_COUNT];

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      for (int i = 0; i < VFT_NUM; i++)
      begin
        for (int s = 0; s < int'(VFT_SEL_LINE_COUNT); s++)
        begin
          mem_ff[i][s] <= VFT_REG_RST;
        end
      end
    end
    else if (i_wr_en && i_wr_sel != VFT_SEL_LINE_COUNT)
    begin
      mem_ff[i_wr_inst][i_wr_sel] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rd_data_ff <= 32'h00000000;
    end
    else if (i_rd_en)
    begin
      if (!i_rd_dec.hit)
      begin
        o_rd_data_ff <= 32'h00000000;
      end
      else if (i_rd_dec.ro)
      begin
        o_rd_data_ff <= {16'h0000, i_line_cnt[i_rd_dec.inst]};
      end
      else
      begin
        o_rd_data_ff <= {16'h0000, mem_ff[i_rd_dec.inst][i_rd_dec.sel]};
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < VFT_NUM; i++)
    begin
      o_regs[i].irq_line = mem_ff[i][VFT_SEL_IRQ_LINE];
      o_regs[i].sync_end = mem_ff[i][VFT_SEL_SYNC_END];
      o_regs[i].area_start = mem_ff[i][VFT_SEL_AREA_START];
      o_regs[i].vblank_start = mem_ff[i][VFT_SEL_VBLANK_START];
      o_regs[i].vblank_end = mem_ff[i][VFT_SEL_VBLANK_END];
      o_regs[i].vertical_total_value = mem_ff[i][VFT_SEL_VERTICAL_TOTAL_VALUE];
      o_regs[i].control = mem_ff[i][VFT_SEL_CONTROL];
    end
  end

endmodule
`default_nettype wire

// ### vft_top.sv
// Vertical half of two frame timers with their APB register slave.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
module vft_top (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Strobes from the horizontal half of each timer.
  input wire vft_pkg::vft_hin_t [1:0] i_hin,
  // Video timing outputs of each timer.
  output vft_pkg::vft_vout_t [1:0] o_vout,
  // Frame interrupt pulses to the host processor pending flags.
  output logic [1:0] o_frame_irq
);
  import vft_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave.

  logic setup;
  logic access;
  logic wr_en;
  logic err_ff;
  vft_dec_t dec;
  vft_vregs_t [1:0] regs;
  logic [1:0][15:0] line_cnt;

  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign dec = vft_decode(i_paddr);
  // The counter slot is read-only; a write there is answered as an error.
  assign wr_en = access && i_pwrite && dec.hit && !dec.ro;

  // Zero wait states: the read word is captured in the setup cycle.
  assign o_pready = 1'b1;
  assign o_pslverr = access && err_ff;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      err_ff <= 1'b0;
    end
    else if (setup)
    begin
      err_ff <= !dec.hit || (dec.ro && i_pwrite);
    end
  end

  vft_regbank u_regbank (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_wr_en(wr_en),
    .i_wr_inst(dec.inst),
    .i_wr_sel(dec.sel),
    .i_wr_data(i_pwdata[15:0]),
    .i_rd_en(setup),
    .i_rd_dec(dec),
    .i_line_cnt(line_cnt),
    .o_rd_data_ff(o_prdata),
    .o_regs(regs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Vertical timers, one copy per frame timer.

  for (genvar g = 0; g < VFT_NUM; g++)
  begin : g_tmr
    vft_vregs_t r;
    vft_hin_t h;
    logic enable;
    logic interlace;
    logic composite;
    logic iis;
    logic step;
    logic mid_step;
    logic [15:0] half_sync;
    logic tot_hit;
    logic half_hit;
    logic end_hit;
    logic bstart_hit;
    logic bend_hit;
    logic area_hit;
    logic irq_hit;
    logic irq_fire;
    logic [15:0] cnt_ff;
    logic vsync_n_ff;
    logic vblank_n_ff;
    logic cblank_n_ff;
    logic composite_sync_output_n_ff;
    logic varea_ff;
    logic serr_ff;
    logic pre_eq_ff;
    logic post_eq_ff;
    logic area_pend_ff;
    logic irq_pend_ff;
    logic field_ff;
    logic irq_done_ff;
    logic irq_ff;

    assign r = regs[g];
    assign h = i_hin[g];
    assign enable = r.control[VFT_CTL_ENABLE];
    assign interlace = r.control[VFT_CTL_INTERLACE];
    assign composite = r.control[VFT_CTL_COMPOSITE];
    assign iis = r.control[VFT_CTL_IIS];

    assign mid_step = enable && interlace && h.midline;
    assign step = (enable && h.line_end) || mid_step;
    assign half_sync = {1'b0, r.sync_end[15:1]};
    assign tot_hit = step && (cnt_ff == r.vertical_total_value);
    assign half_hit = step && (cnt_ff == half_sync);
    assign end_hit = step && (cnt_ff == r.sync_end);
    assign bstart_hit = step && (cnt_ff == r.vblank_start);
    assign bend_hit = step && (cnt_ff == r.vblank_end);

    // Area and interrupt only rise at full line ends; a midline match is
    // parked and applied at the next line end.
    assign area_hit = enable && h.line_end
      && ((cnt_ff == r.area_start) || area_pend_ff);
    assign irq_hit = enable && h.line_end
      && ((cnt_ff == r.irq_line) || irq_pend_ff);
    // Frame mode suppresses the second field's match.
    assign irq_fire = irq_hit && !(interlace && !iis && irq_done_ff);

    assign line_cnt[g] = cnt_ff;

    // Line counter.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        cnt_ff <= VFT_CNT_RST;
      end
      else if (!enable)
      begin
        cnt_ff <= VFT_CNT_RST;
      end
      else if (tot_hit)
      begin
        cnt_ff <= VFT_CNT_RST;
      end
      else if (step)
      begin
        cnt_ff <= cnt_ff + VFT_CNT_ONE;
      end
    end

    // Vertical sync.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        vsync_n_ff <= 1'b1;
      end
      else if (tot_hit)
      begin
        vsync_n_ff <= 1'b0;
      end
      else if (half_hit)
      begin
        vsync_n_ff <= 1'b1;
      end
    end

    // Vertical blanking.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        vblank_n_ff <= 1'b1;
      end
      else if (bstart_hit)
      begin
        vblank_n_ff <= 1'b0;
      end
      else if (bend_hit)
      begin
        vblank_n_ff <= 1'b1;
      end
    end

    // Serration region, composite mode only.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        serr_ff <= 1'b0;
      end
      else if (!composite)
      begin
        serr_ff <= 1'b0;
      end
      else if (tot_hit)
      begin
        serr_ff <= 1'b1;
      end
      else if (half_hit)
      begin
        serr_ff <= 1'b0;
      end
    end

    // Pre-equalization region, interlaced composite mode only.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        pre_eq_ff <= 1'b0;
      end
      else if (!(composite && interlace))
      begin
        pre_eq_ff <= 1'b0;
      end
      else if (tot_hit)
      begin
        pre_eq_ff <= 1'b0;
      end
      else if (bstart_hit)
      begin
        pre_eq_ff <= 1'b1;
      end
    end

    // Post-equalization region, interlaced composite mode only.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        post_eq_ff <= 1'b0;
      end
      else if (!(composite && interlace))
      begin
        post_eq_ff <= 1'b0;
      end
      else if (half_hit)
      begin
        post_eq_ff <= 1'b1;
      end
      else if (end_hit)
      begin
        post_eq_ff <= 1'b0;
      end
    end

    // Midline matches parked until the line end.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        area_pend_ff <= 1'b0;
        irq_pend_ff <= 1'b0;
      end
      else if (mid_step)
      begin
        area_pend_ff <= (cnt_ff == r.area_start);
        irq_pend_ff <= (cnt_ff == r.irq_line);
      end
      else if (h.line_end || !enable)
      begin
        area_pend_ff <= 1'b0;
        irq_pend_ff <= 1'b0;
      end
    end

    // Vertical area component; it is dropped when each field's sync starts.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        varea_ff <= 1'b0;
      end
      else if (area_hit)
      begin
        varea_ff <= 1'b1;
      end
      else if (tot_hit || !enable)
      begin
        varea_ff <= 1'b0;
      end
    end

    // Field parity; field 0 begins when the second field wraps.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        field_ff <= 1'b0;
      end
      else if (!interlace || !enable)
      begin
        field_ff <= 1'b0;
      end
      else if (tot_hit)
      begin
        field_ff <= !field_ff;
      end
    end

    // Frame mode bookkeeping; the firing wins over a frame-start clear.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        irq_done_ff <= 1'b0;
      end
      else if (irq_fire)
      begin
        irq_done_ff <= 1'b1;
      end
      else if ((tot_hit && field_ff) || !interlace || iis)
      begin
        irq_done_ff <= 1'b0;
      end
    end

    // Interrupt pulse, one cycle.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        irq_ff <= 1'b0;
      end
      else
      begin
        irq_ff <= irq_fire;
      end
    end

    // Composite outputs are registered, one cycle behind the horizontal shapes and vblank_n_ff.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        cblank_n_ff <= 1'b1;
        composite_sync_output_n_ff <= 1'b1;
      end
      else
      begin
        cblank_n_ff <= h.hblank_n && vblank_n_ff;
        if (serr_ff)
        begin
          composite_sync_output_n_ff <= h.serrate_n;
        end
        else if (pre_eq_ff || post_eq_ff)
        begin
          composite_sync_output_n_ff <= h.equalize_n;
        end
        else
        begin
          composite_sync_output_n_ff <= h.hsync_n;
        end
      end
    end

    assign o_vout[g].vsync_n = vsync_n_ff;
    assign o_vout[g].vblank_n = vblank_n_ff;
    assign o_vout[g].cblank_n = cblank_n_ff;
    assign o_vout[g].composite_sync_output_n = composite_sync_output_n_ff;
    assign o_vout[g].varea = varea_ff;
    assign o_vout[g].serration = serr_ff;
    assign o_vout[g].equalization = pre_eq_ff || post_eq_ff;
    assign o_frame_irq[g] = irq_ff;
  end

endmodule
`default_nettype wire

// ### vft_hgen.sv
// Behavioural horizontal half that feeds line and midline strobes.
`timescale 1ns/1ps
`default_nettype none
module vft_hgen #(
  parameter int HT0 = 9,
  parameter int HT1 = 13
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Per timer run and midline enables.
  input wire logic [1:0] i_run,
  input wire logic [1:0] i_half,
  // Strobes and pulse shapes.
  output vft_pkg::vft_hin_t [1:0] o_hin
);
  import vft_pkg::*;
  localparam int HT [2] = '{HT0, HT1};
  logic [7:0] pix_ff [2];

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pix_ff <= '{8'h00, 8'h00};
    end
    else
    begin
      for (int g = 0; g < 2; g++)
      begin
        pix_ff[g] <= (!i_run[g] || pix_ff[g] == 8'(HT[g])) ? 8'h00 :
                     pix_ff[g] + 8'h01;
      end
    end
  end

  // Idle pulse shapes are all high and strobes low so composite outputs stay quiet when stopped.
  always_comb
  begin
    for (int g = 0; g < 2; g++)
    begin
      o_hin[g] = '1;
      o_hin[g].line_end = i_run[g] && pix_ff[g] == 8'(HT[g]);
      o_hin[g].midline = i_run[g] && i_half[g] &&
                         pix_ff[g] == 8'(HT[g] / 2);
      if (i_run[g])
      begin
        o_hin[g].hsync_n = pix_ff[g] > 8'h01;
        o_hin[g].hblank_n = pix_ff[g] > 8'h02;
        o_hin[g].equalize_n = pix_ff[g] != 8'h00;
        o_hin[g].serrate_n = pix_ff[g] < 8'h05;
      end
    end
  end
endmodule
`default_nettype wire

// ### vft_top_monitor.sv
// Port-level checker for the vertical frame timer.
`timescale 1ns/1ps
`default_nettype none
module vft_top_monitor (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // APB.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Timing.
  input wire vft_pkg::vft_hin_t [1:0] i_hin,
  input wire vft_pkg::vft_vout_t [1:0] o_vout,
  input wire logic [1:0] o_frame_irq
);
  import vft_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_access;
    i_psel && i_penable;
  endsequence
  property p_ready;
    i_psel |-> o_pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("pready low during a transfer");
  property p_err_scope;
    o_pslverr |-> s_access;
  endproperty
  a_err_scope: assert property (p_err_scope)
    else $error("pslverr outside an access phase");

  //////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < 2; g++)
  begin : g_t
    // A vertical level may only move on the edge that took a step.
    sequence s_step;
      $past(i_hin[g].line_end || i_hin[g].midline);
    endsequence
    sequence s_pulse;
      o_frame_irq[g] ##1 !o_frame_irq[g];
    endsequence
    property p_vsync;
      $changed(o_vout[g].vsync_n) |-> s_step;
    endproperty
    a_vsync: assert property (p_vsync)
      else $error("vsync moved without a step");
    property p_vblank;
      $changed(o_vout[g].vblank_n) |-> s_step;
    endproperty
    a_vblank: assert property (p_vblank)
      else $error("vblank moved without a step");
    property p_serr;
      $changed(o_vout[g].serration) |-> s_step;
    endproperty
    a_serr: assert property (p_serr)
      else $error("serration moved without a step");
    property p_eq;
      $changed(o_vout[g].equalization) |-> s_step;
    endproperty
    a_eq: assert property (p_eq)
      else $error("equalization moved without a step");
    property p_area;
      $rose(o_vout[g].varea) |-> $past(i_hin[g].line_end);
    endproperty
    a_area: assert property (p_area)
      else $error("area rose away from a line end");
    property p_irq_le;
      o_frame_irq[g] |-> $past(i_hin[g].line_end);
    endproperty
    a_irq_le: assert property (p_irq_le)
      else $error("interrupt away from a line end");
    property p_irq_pulse;
      $rose(o_frame_irq[g]) |-> s_pulse;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
      else $error("interrupt longer than one cycle");
    property p_cblank;
      o_vout[g].cblank_n == $past(i_hin[g].hblank_n && o_vout[g].vblank_n);
    endproperty
    a_cblank: assert property (p_cblank)
      else $error("composite blanking mismatch");
    property p_composite_sync_output;
      o_vout[g].composite_sync_output_n == $past(o_vout[g].serration ? i_hin[g].serrate_n :
        o_vout[g].equalization ? i_hin[g].equalize_n : i_hin[g].hsync_n);
    endproperty
    a_composite_sync_output: assert property (p_composite_sync_output)
      else $error("composite sync source mismatch");
  end
endmodule

bind vft_top vft_top_monitor u_mon (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_hin(i_hin), .o_vout(o_vout),
  .o_frame_irq(o_frame_irq)
);
`default_nettype wire

// ### vft_top_tb.sv
// Self-checking bench for the vertical frame timer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module vft_top_tb;
  import vft_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] run = 2'h0;
  logic [1:0] half = 2'h0;
  vft_hin_t [1:0] hin;
  vft_vout_t [1:0] vout;
  logic [1:0] irq;
  logic [31:0] rdat;
  logic rerr;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  vft_hgen u_hgen (.i_clk(clk), .i_reset_n(reset_n), .i_run(run),
    .i_half(half), .o_hin(hin));
  vft_top dut (.i_clk(clk), .i_reset_n(reset_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_hin(hin), .o_vout(vout), .o_frame_irq(irq));

  //////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      conclude();
    end
  end

  function automatic logic [31:0] ra(input int t, input int s);
    return VFT_IDX_TAB[t][s] << 2;
  endfunction

  // Read data and error are taken at the edge where pready is sampled.
  task automatic rw(input logic w, input logic [31:0] a,
                    input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs();
    for (int t = 0; t < 2; t++)
      for (int s = 0; s < 6; s++)
      begin
        rw(1'b0, ra(t, s), 16'h0000);
        `CHK(rdat, 32'h0)
        rw(1'b1, ra(t, s), 16'hfff0 | 16'(t * 8 + s));
      end
    for (int t = 0; t < 2; t++)
      for (int s = 0; s < 6; s++)
      begin
        rw(1'b0, ra(t, s), 16'h0000);
        `CHK(rdat, {16'h0000, 16'hfff0 | 16'(t * 8 + s)})
      end
    rw(1'b0, 32'h00000100, 16'h0000);
    `CHK({rerr, rdat}, {1'b1, 32'h0})
    rw(1'b1, ra(0, 7), 16'h0005);
    `CHK(rerr, 1'b1)
    rw(1'b0, ra(0, 7), 16'h0000);
    `CHK({rerr, rdat}, {1'b0, 32'h0})
  endtask

  // Noninterlaced composite timer 0 against a small reference.
  task automatic t_frame();
    logic [15:0] v [6];
    logic [15:0] c;
    logic vs;
    logic vb;
    logic ar;
    v = '{16'h0002, 16'h0003, 16'h0001, 16'h0002, 16'h0000, 16'h0003};
    c = 16'h0000;
    vs = 1'b1;
    vb = 1'b1;
    ar = 1'b0;
    for (int s = 0; s < 6; s++)
      rw(1'b1, ra(0, s), v[s]);
    rw(1'b1, ra(0, 6), 16'h0005);
    run[0] <= 1'b1;
    repeat (12)
    begin
      do @(posedge clk); while (hin[0].line_end !== 1'b1);
      #1;
      `CHK(irq[0], c == 16'h0002)
      vs = (c == 16'h0003) ? 1'b0 : (c == 16'h0001) ? 1'b1 : vs;
      vb = (c == 16'h0002) ? 1'b0 : (c == 16'h0000) ? 1'b1 : vb;
      ar = (c == 16'h0001) ? 1'b1 : (c == 16'h0003) ? 1'b0 : ar;
      c = (c == 16'h0003) ? 16'h0000 : c + 16'h0001;
      `CHK(vout[0].vsync_n, vs)
      `CHK(vout[0].serration, !vs)
      `CHK(vout[0].vblank_n, vb)
      `CHK(vout[0].varea, ar)
      rw(1'b0, ra(0, 7), 16'h0000);
      `CHK(rdat, {16'h0000, c})
    end
  endtask

  // Interlaced composite timer 1: irq count per two frames, both modes.
  task automatic t_lace();
    logic [15:0] v [6];
    int n;
    int ne;
    int ns;
    int nv;
    v = '{16'h0002, 16'h0003, 16'h0001, 16'h0004, 16'h0001, 16'h0006};
    for (int s = 0; s < 6; s++)
      rw(1'b1, ra(1, s), v[s]);
    for (int m = 0; m < 2; m++)
    begin
      rw(1'b1, ra(1, 6), (m == 0) ? 16'h0007 : 16'h000f);
      run[1] <= 1'b1;
      half[1] <= 1'b1;
      n = 0;
      ne = 0;
      ns = 0;
      nv = 0;
      // Two whole frames of 14 halflines of 7 cycles each are watched.
      repeat (196)
      begin
        @(posedge clk);
        if (irq[1] === 1'b1)
          n++;
        if (vout[1].equalization === 1'b1)
          ne++;
        if (vout[1].serration === 1'b1)
          ns++;
        if (vout[1].vsync_n === 1'b0)
          nv++;
      end
      // Each field has two halflines of pre and two of post equalization.
      `CHK(ne, 112)
      // The very first field starts without a sync, so one region is absent.
      `CHK(ns, (m == 0) ? 42 : 56)
      `CHK(nv, (m == 0) ? 42 : 56)
      if (m == 0)
        `CHK(n, 2)
      else
        `CHK(n, 4)
    end
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_frame();
    t_lace();
    conclude();
  end
endmodule
`default_nettype wire
